//--- bench/aam_alu_chk.sv
// Port checker for the accumulator ALU datapath.
`timescale 1ns/100ps
`default_nettype none
module aam_alu_chk (
   input wire logic clk,
   input wire logic nrst,
   input wire logic opStart,
   input wire aam_pkg::aam_op_e opCode,
   input wire logic [7:0] operandByte,
   input wire logic operandBit,
   input wire logic destIsMem,
   input wire logic opBusy,
   input wire logic opDone,
   input wire logic [7:0] accumulator,
   input wire logic [7:0] auxOperand,
   input wire logic carryFlag,
   input wire logic overflowFlag,
   input wire logic memWrite,
   input wire logic [7:0] memWriteData
);
   import aam_pkg::*;
   default clocking cb @(posedge clk); endclocking
   default disable iff (!nrst);
   logic taken;
   logic bitSel;
   logic isOr;
   logic carryExp;
   assign taken = opStart && !opBusy;
   assign bitSel = (opCode == AAM_OP_CAND_N || opCode == AAM_OP_COR_N) ? ~operandBit : operandBit;
   assign isOr = (opCode == AAM_OP_COR || opCode == AAM_OP_COR_N);
   always_ff @(posedge clk) begin
      carryExp <= isOr ? (carryFlag | bitSel) : (carryFlag & bitSel);
   end
   property p_rot_r;
      taken && opCode == AAM_OP_ROT_R |=> accumulator == {$past(accumulator[0]),
         $past(accumulator[7:1])} && carryFlag == $past(carryFlag);
   endproperty
   a_rot_r: assert property (p_rot_r) else $error("plain right rotate wrong");
   property p_rot_rc;
      taken && opCode == AAM_OP_ROT_RC |=> accumulator == {$past(carryFlag),
         $past(accumulator[7:1])} && carryFlag == $past(accumulator[0]);
   endproperty
   a_rot_rc: assert property (p_rot_rc) else $error("right carry rotate wrong");
   property p_rot_l;
      taken && opCode == AAM_OP_ROT_L |=> accumulator == {$past(accumulator[6:0]),
         $past(accumulator[7])} && $stable(carryFlag);
   endproperty
   a_rot_l: assert property (p_rot_l) else $error("plain left rotate wrong");
   property p_rot_lc;
      taken && opCode == AAM_OP_ROT_LC |=> accumulator == {$past(accumulator[6:0]),
         $past(carryFlag)} && carryFlag == $past(accumulator[7]);
   endproperty
   a_rot_lc: assert property (p_rot_lc) else $error("left carry rotate wrong");
   property p_carry_logic;
      taken && opCode inside {AAM_OP_CAND, AAM_OP_CAND_N, AAM_OP_COR, AAM_OP_COR_N}
         |=> carryFlag == carryExp && !memWrite && $stable(accumulator);
   endproperty
   a_carry_logic: assert property (p_carry_logic) else $error("carry bit logic wrong");
   property p_exch;
      taken && opCode == AAM_OP_EXCH |=> accumulator == $past(operandByte) && memWrite
         && memWriteData == $past(accumulator);
   endproperty
   a_exch: assert property (p_exch) else $error("byte exchange wrong");
   property p_nib_exch;
      taken && opCode == AAM_OP_NIB_EXCH |=> memWrite && accumulator == {$past(accumulator[7:4]),
         $past(operandByte[3:0])} && memWriteData == {$past(operandByte[7:4]),
         $past(accumulator[3:0])};
   endproperty
   a_nib_exch: assert property (p_nib_exch) else $error("nibble exchange wrong");
   property p_div;
      taken && opCode == AAM_OP_DIVIDE && auxOperand != 8'h00 |=> opBusy [*8] ##1 (opDone
         && !carryFlag && !overflowFlag && accumulator == $past(accumulator, 9) / $past(auxOperand, 9)
         && auxOperand == $past(accumulator, 9) % $past(auxOperand, 9));
   endproperty
   a_div: assert property (p_div) else $error("divide result wrong");
   property p_div_zero;
      taken && opCode == AAM_OP_DIVIDE && auxOperand == 8'h00 |=> opBusy ##1 (opDone
         && overflowFlag && !carryFlag);
   endproperty
   a_div_zero: assert property (p_div_zero) else $error("zero divisor flags wrong");
endmodule
bind aam_alu aam_alu_chk u_chk (.clk(clk), .nrst(nrst), .opStart(opStart), .opCode(opCode),
   .operandByte(operandByte), .operandBit(operandBit), .destIsMem(destIsMem), .opBusy(opBusy),
   .opDone(opDone), .accumulator(accumulator), .auxOperand(auxOperand), .carryFlag(carryFlag),
   .overflowFlag(overflowFlag), .memWrite(memWrite), .memWriteData(memWriteData));
`default_nettype wire

//--- bench/aam_ram_model.sv
// One addressed RAM byte of the core, fed to the datapath and updated by its write-back.
`timescale 1ns/100ps
`default_nettype none
module aam_ram_model (
   input wire logic clk,
   input wire logic nrst,
   input wire logic loadEn,
   input wire logic [7:0] loadData,
   input wire logic memWrite,
   input wire logic [7:0] memWriteData,
   output logic [7:0] memByte
);
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         memByte <= 8'h00;
      end else if (loadEn) begin
         memByte <= loadData;
      end else if (memWrite) begin
         memByte <= memWriteData;
      end
   end
endmodule
`default_nettype wire

//--- bench/accumulator_alu_misc_ops_bench.sv
// Self-checking testbench for the accumulator ALU datapath.
`timescale 1ns/100ps
`default_nettype none
module accumulator_alu_misc_ops_bench;
   import aam_pkg::*;
   logic clk, nrst, opStart, operandBit, destIsMem, opBusy, opDone, carryFlag, overflowFlag;
   logic memWrite, loadEn;
   logic [7:0] memByte, accumulator, auxOperand, memWriteData, loadData;
   aam_op_e opCode;
   int mismatches = 0;
   int comparisons = 0;
   always #50 clk = ~clk;
   aam_alu dut (.clk(clk), .nrst(nrst), .opStart(opStart), .opCode(opCode),
      .operandByte(memByte), .operandBit(operandBit), .destIsMem(destIsMem), .opBusy(opBusy),
      .opDone(opDone), .accumulator(accumulator), .auxOperand(auxOperand), .carryFlag(carryFlag),
      .overflowFlag(overflowFlag), .memWrite(memWrite), .memWriteData(memWriteData));
   aam_ram_model ram (.clk(clk), .nrst(nrst), .loadEn(loadEn), .loadData(loadData),
      .memWrite(memWrite), .memWriteData(memWriteData), .memByte(memByte));
   task automatic conclude();
      if (mismatches == 0 && comparisons > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      comparisons++;
      if (seen !== exp) begin
         mismatches++;
         $display("ERROR %0t saw %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic load(input logic [7:0] v);
      @(posedge clk);
      loadEn <= 1'b1;
      loadData <= v;
      @(posedge clk);
      loadEn <= 1'b0;
   endtask
   // Returns one cycle after completion so the write-back has reached the RAM byte.
   task automatic op(input aam_op_e code, input logic bitv, input logic dmem);
      int i;
      @(posedge clk);
      opStart <= 1'b1;
      opCode <= code;
      operandBit <= bitv;
      destIsMem <= dmem;
      @(posedge clk);
      opStart <= 1'b0;
      for (i = 0; i < 20; i++) begin
         @(negedge clk);
         if (opDone === 1'b1) break;
      end
      if (i == 20) begin
         mismatches++;
         conclude();
      end
      @(negedge clk);
   endtask
   task automatic t_div_zero();
      op(AAM_OP_DIVIDE, 1'b0, 1'b0);
      check(16'({carryFlag, overflowFlag}), 16'h0001);
      check({accumulator, auxOperand}, {DIV_ZERO_FILL, DIV_ZERO_FILL});
   endtask
   // The divisor can only be set as a remainder or as DIV_ZERO_FILL, so the steps are chained.
   task automatic t_div(input logic [7:0] v, old, q, r);
      load(v);
      op(AAM_OP_EXCH, 1'b0, 1'b0);
      check({accumulator, memByte}, {v, old});
      op(AAM_OP_COR_N, 1'b0, 1'b0);
      check(16'(carryFlag), 16'h0001);
      op(AAM_OP_DIVIDE, 1'b0, 1'b0);
      check({accumulator, auxOperand}, {q, r});
      check(16'({carryFlag, overflowFlag}), 16'h0000);
   endtask
   task automatic t_rot();
      aam_op_e ops[6] = '{AAM_OP_ROT_RC, AAM_OP_ROT_RC, AAM_OP_ROT_R, AAM_OP_ROT_LC,
         AAM_OP_ROT_L, AAM_OP_SWAP};
      logic [8:0] exp[6] = '{9'h04B, 9'h125, 9'h192, 9'h125, 9'h14A, 9'h1A4};
      load(8'h96);
      op(AAM_OP_EXCH, 1'b0, 1'b0);
      for (int k = 0; k < 6; k++) begin
         op(ops[k], 1'b0, 1'b0);
         check(16'({carryFlag, accumulator}), 16'(exp[k]));
      end
   endtask
   task automatic t_logic();
      load(8'h35);
      op(AAM_OP_AND, 1'b0, 1'b0);
      check({accumulator, memByte}, 16'h2435);
      load(8'h41);
      op(AAM_OP_OR, 1'b0, 1'b1);
      check({accumulator, memByte}, 16'h2465);
      op(AAM_OP_XOR, 1'b0, 1'b0);
      check({accumulator, memByte}, 16'h4165);
   endtask
   task automatic t_carry();
      aam_op_e ops[8] = '{AAM_OP_CAND, AAM_OP_CAND_N, AAM_OP_COR, AAM_OP_COR, AAM_OP_CAND,
         AAM_OP_COR_N, AAM_OP_COR_N, AAM_OP_CAND_N};
      logic [7:0] bits = 8'b0010_1001;
      // Carry enters at one from the rotate scenario; bit k of exp is the carry after step k.
      logic [7:0] exp = 8'b1100_1111;
      for (int k = 0; k < 8; k++) begin
         op(ops[k], bits[k], 1'b0);
         check(16'(carryFlag), 16'(exp[k]));
         check({accumulator, memByte}, 16'h4165);
      end
   endtask
   task automatic t_nib();
      load(8'h24);
      op(AAM_OP_EXCH, 1'b0, 1'b0);
      load(8'h87);
      op(AAM_OP_NIB_EXCH, 1'b0, 1'b0);
      check({accumulator, memByte}, 16'h2784);
   endtask
   initial begin
      clk = 1'b0;
      nrst = 1'b0;
      opStart = 1'b0;
      opCode = AAM_OP_NONE;
      operandBit = 1'b0;
      destIsMem = 1'b0;
      loadEn = 1'b0;
      loadData = 8'h00;
      repeat (16) @(posedge clk);
      nrst <= 1'b1;
      t_div_zero();
      t_div(8'hF3, 8'hFF, 8'h00, 8'hF3);
      t_div(8'h20, 8'h00, 8'h00, 8'h20);
      t_div(8'hF3, 8'h00, 8'h07, 8'h13);
      t_div(8'hF3, 8'h07, 8'h0C, 8'h0F);
      t_rot();
      t_logic();
      t_carry();
      t_nib();
      conclude();
   end
endmodule
`default_nettype wire

//--- design/aam_alu.sv
// Accumulator-centred ALU for divide, rotates, logic, carry-bit logic and exchanges.
`timescale 1ns/100ps
`default_nettype none
// How it works
// - Divide puts quotient of accumulator over auxiliary into accumulator, remainder into auxiliary.
// - Divide clears carry and overflow; a zero divisor sets overflow instead.
// - A zero divisor leaves accumulator and auxiliary with the fixed fill value DIV_ZERO_FILL.
// - Division is eight bits by eight bits only, giving eight-bit quotient and remainder.
// - Plain right rotate moves bits down, bit 0 wraps to bit 7.
// - Right rotate through carry: bit 0 into carry, old carry into bit 7.
// - Plain left rotate moves bits up, bit 7 wraps to bit 0.
// - Left rotate through carry: bit 7 into carry, old carry into bit 0.
// - Plain rotates leave carry alone; only through-carry rotates touch it.
// - Byte logic writes to accumulator or RAM byte, the first operand.
// - Byte AND sets a bit only where both operand bits are one.
// - Byte OR sets a bit where either operand bit is one.
// - Byte XOR sets a bit where exactly one operand bit is one.
// - Carry AND bit keeps carry only when carry and bit are both one.
// - Carry AND inverted bit: a set bit clears carry.
// - Carry OR bit sets carry when either carry or bit is one.
// - Carry OR inverted bit: a clear bit sets carry.
// - Carry logic writes only carry and never the addressed bit.
// - No carry XOR with a bit exists; only AND and OR forms.
// - Exchange writes accumulator to location and location value to accumulator.
// - Swap exchanges accumulator nibbles, same as four plain left rotates.
// - Low-nibble exchange swaps low nibbles of accumulator and location, uppers kept.
module aam_alu
   import aam_pkg::*;
#(
   parameter int unsigned WIDTH = aam_pkg::DATA_W
) (
   input wire logic clk,
   input wire logic nrst,
   input wire logic opStart,
   input wire aam_pkg::aam_op_e opCode,
   input wire logic [7:0] operandByte,
   input wire logic operandBit,
   input wire logic destIsMem,
   output logic opBusy,
   output logic opDone,
   output logic [7:0] accumulator,
   output logic [7:0] auxOperand,
   output logic carryFlag,
   output logic overflowFlag,
   output logic memWrite,
   output logic [7:0] memWriteData
);
   import aam_pkg::*;

   typedef struct packed {
      aam_state_e state;
      logic [7:0] acc;
      logic [7:0] aux;
      logic carry;
      logic ovf;
      logic done;
      logic memWr;
      logic [7:0] memData;
      logic [3:0] stepCnt;
      logic [7:0] quot;
      logic [7:0] rem;
      logic [7:0] dividend;
      logic [7:0] divisor;
   } aam_state_s;

   aam_state_s st_reg;
   aam_state_s st_next;

   logic [7:0] stepRem;
   logic stepQuot;

   // One divider step per cycle keeps the combinational depth to a single subtractor.
   aam_div_step #(
      .W(8)
   ) u_step (
      .partRem(st_reg.rem),
      .dividendBit(st_reg.dividend[7]),
      .divisor(st_reg.divisor),
      .nextRem(stepRem),
      .quotBit(stepQuot)
   );

   always_comb begin
      st_next = st_reg;
      st_next.done = 1'b0;
      st_next.memWr = 1'b0;
      case (st_reg.state)
         AAM_ST_IDLE: begin
            if (opStart) begin
               st_next.done = 1'b1;
               case (opCode)
                  AAM_OP_DIVIDE: begin
                     st_next.done = 1'b0;
                     st_next.dividend = st_reg.acc;
                     st_next.divisor = st_reg.aux;
                     st_next.rem = 8'h00;
                     st_next.quot = 8'h00;
                     st_next.stepCnt = 4'h0;
                     st_next.state = AAM_ST_DIV;
                  end
                  AAM_OP_ROT_R: begin
                     st_next.acc = {st_reg.acc[0], st_reg.acc[7:1]};
                  end
                  AAM_OP_ROT_RC: begin
                     st_next.acc = {st_reg.carry, st_reg.acc[7:1]};
                     st_next.carry = st_reg.acc[0];
                  end
                  AAM_OP_ROT_L: begin
                     st_next.acc = {st_reg.acc[6:0], st_reg.acc[7]};
                  end
                  AAM_OP_ROT_LC: begin
                     st_next.acc = {st_reg.acc[6:0], st_reg.carry};
                     st_next.carry = st_reg.acc[7];
                  end
                  AAM_OP_AND, AAM_OP_OR, AAM_OP_XOR: begin
                     logic [7:0] first;
                     logic [7:0] res;
                     first = 8'h00;
                     res = 8'h00;
                     // For a RAM destination the decoder supplies the RAM byte as
                     // operandByte and the accumulator is the second operand.
                     first = destIsMem ? operandByte : st_reg.acc;
                     if (opCode == AAM_OP_AND) begin
                        res = first & st_reg.acc;
                     end else if (opCode == AAM_OP_OR) begin
                        res = first | st_reg.acc;
                     end else begin
                        res = first ^ st_reg.acc;
                     end
                     if (!destIsMem) begin
                        // Accumulator destination: second operand is operandByte.
                        if (opCode == AAM_OP_AND) begin
                           res = st_reg.acc & operandByte;
                        end else if (opCode == AAM_OP_OR) begin
                           res = st_reg.acc | operandByte;
                        end else begin
                           res = st_reg.acc ^ operandByte;
                        end
                        st_next.acc = res;
                     end else begin
                        st_next.memWr = 1'b1;
                        st_next.memData = res;
                     end
                  end
                  AAM_OP_CAND: begin
                     st_next.carry = st_reg.carry & operandBit;
                  end
                  AAM_OP_CAND_N: begin
                     st_next.carry = st_reg.carry & ~operandBit;
                  end
                  AAM_OP_COR: begin
                     st_next.carry = st_reg.carry | operandBit;
                  end
                  AAM_OP_COR_N: begin
                     st_next.carry = st_reg.carry | ~operandBit;
                  end
                  AAM_OP_EXCH: begin
                     st_next.acc = operandByte;
                     st_next.memWr = 1'b1;
                     st_next.memData = st_reg.acc;
                  end
                  AAM_OP_SWAP: begin
                     st_next.acc = {st_reg.acc[3:0], st_reg.acc[7:4]};
                  end
                  AAM_OP_NIB_EXCH: begin
                     st_next.acc = {st_reg.acc[7:4], operandByte[3:0]};
                     st_next.memWr = 1'b1;
                     st_next.memData = {operandByte[7:4], st_reg.acc[3:0]};
                  end
                  default: begin
                     // No-op, the only code not handled above, changes nothing.
                     st_next.done = 1'b1;
                  end
               endcase
            end
         end
         AAM_ST_DIV: begin
            if (st_reg.divisor == 8'h00) begin
               st_next.acc = DIV_ZERO_FILL;
               st_next.aux = DIV_ZERO_FILL;
               st_next.carry = 1'b0;
               st_next.ovf = 1'b1;
               st_next.done = 1'b1;
               st_next.state = AAM_ST_IDLE;
            end else begin
               st_next.rem = stepRem;
               st_next.quot = {st_reg.quot[6:0], stepQuot};
               st_next.dividend = {st_reg.dividend[6:0], 1'b0};
               st_next.stepCnt = st_reg.stepCnt + 4'h1;
               if (st_reg.stepCnt == DIV_STEPS - 4'h1) begin
                  // Quotient, remainder and flags land in one edge.
                  st_next.acc = {st_reg.quot[6:0], stepQuot};
                  st_next.aux = stepRem;
                  st_next.carry = 1'b0;
                  st_next.ovf = 1'b0;
                  st_next.done = 1'b1;
                  st_next.state = AAM_ST_IDLE;
               end
            end
         end
         default: begin
            st_next.state = AAM_ST_IDLE;
         end
      endcase
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         st_reg.state <= AAM_ST_IDLE;
         st_reg.acc <= ACC_RESET;
         st_reg.aux <= AUX_RESET;
         st_reg.carry <= CARRY_RESET;
         st_reg.ovf <= OVF_RESET;
         st_reg.done <= 1'b0;
         st_reg.memWr <= 1'b0;
         st_reg.memData <= 8'h00;
         st_reg.stepCnt <= 4'h0;
         st_reg.quot <= 8'h00;
         st_reg.rem <= 8'h00;
         st_reg.dividend <= 8'h00;
         st_reg.divisor <= 8'h00;
      end else begin
         st_reg <= st_next;
      end
   end

   assign opBusy = (st_reg.state != AAM_ST_IDLE);
   assign opDone = st_reg.done;
   assign accumulator = st_reg.acc;
   assign auxOperand = st_reg.aux;
   assign carryFlag = st_reg.carry;
   assign overflowFlag = st_reg.ovf;
   assign memWrite = st_reg.memWr;
   assign memWriteData = st_reg.memData;
endmodule
`default_nettype wire

//--- design/aam_div_step.sv
// One restoring division step: shift in a dividend bit and try to subtract the divisor.
`timescale 1ns/100ps
`default_nettype none
module aam_div_step #(
   parameter int unsigned W = 8
) (
   input wire logic [W-1:0] partRem,
   input wire logic dividendBit,
   input wire logic [W-1:0] divisor,
   output logic [W-1:0] nextRem,
   output logic quotBit
);
   logic [W:0] shifted;
   logic [W:0] diff;

   always_comb begin
      shifted = {partRem, dividendBit};
      diff = shifted - {1'b0, divisor};
      quotBit = ~diff[W];
      // The remainder stays below the divisor, so it always fits in W bits.
      if (quotBit) begin
         nextRem = diff[W-1:0];
      end else begin
         nextRem = shifted[W-1:0];
      end
   end
endmodule
`default_nettype wire

//--- design/aam_pkg.sv
// Package with operation codes and constants for the accumulator ALU datapath.
package aam_pkg;
   localparam int unsigned DATA_W = 8;
   localparam int unsigned NIB_W = 4;
   localparam logic [7:0] ACC_RESET = 8'h00;
   localparam logic [7:0] AUX_RESET = 8'h00;
   localparam logic CARRY_RESET = 1'b0;
   localparam logic OVF_RESET = 1'b0;
   // Divide steps: one restoring step per quotient bit.
   localparam logic [3:0] DIV_STEPS = 4'h8;
   // Value left in both registers after a divide by zero.
   localparam logic [7:0] DIV_ZERO_FILL = 8'hFF;

   typedef enum logic [3:0] {
      AAM_OP_NONE        = 4'b0000,
      AAM_OP_DIVIDE      = 4'b0001,
      AAM_OP_ROT_R       = 4'b0010,
      AAM_OP_ROT_RC      = 4'b0011,
      AAM_OP_ROT_L       = 4'b0100,
      AAM_OP_ROT_LC      = 4'b0101,
      AAM_OP_AND         = 4'b0110,
      AAM_OP_OR          = 4'b0111,
      AAM_OP_XOR         = 4'b1000,
      AAM_OP_CAND        = 4'b1001,
      AAM_OP_CAND_N      = 4'b1010,
      AAM_OP_COR         = 4'b1011,
      AAM_OP_COR_N       = 4'b1100,
      AAM_OP_EXCH        = 4'b1101,
      AAM_OP_SWAP        = 4'b1110,
      AAM_OP_NIB_EXCH    = 4'b1111
   } aam_op_e;

   typedef enum logic [1:0] {
      AAM_ST_IDLE = 2'b00,
      AAM_ST_DIV  = 2'b01,
      AAM_ST_DONE = 2'b10
   } aam_state_e;
endpackage
